//--- hw/line_test_map.vh
`ifndef LINE_TEST_MAP_VH
`define LINE_TEST_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_TEST_MODE    8'h0f
`define ADDR_LOOPBACK     8'h10
`define ADDR_FAR_END      8'h11
`define ADDR_NEAR_END     8'h12
`define ADDR_BIT_ERR_LO   8'h13
`define ADDR_BIT_ERR_HI   8'h14

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_TEST_MODE     8'h40
`define RST_LOOPBACK      8'h08
`define RST_COUNT8        8'h00
`define RST_COUNT16       16'h0000

// ----------------------------------------------------------------------------
// Test mode control fields
// ----------------------------------------------------------------------------
`define TM_TONE_BIT       0
`define TM_REDUCE_BIT     2
`define TM_CRC_BIT        3
`define TM_SEL_LO         4
`define TM_SEL_HI         5
`define TM_WMASK          8'h3d
`define TM_FIXED          8'h40

// ----------------------------------------------------------------------------
// Measurement select codes
// ----------------------------------------------------------------------------
`define SEL_OFF           2'b00
`define SEL_B1            2'b01
`define SEL_B2            2'b10
`define SEL_ALL           2'b11

// ----------------------------------------------------------------------------
// Loopback control fields
// ----------------------------------------------------------------------------
`define LP_B1_BIT         0
`define LP_B2_BIT         1
`define LP_FULL_BIT       2
`define LP_DIR_BIT        4
`define LP_LOOP_TRANSPARENCY_SELECT_BIT      5
`define LP_FRAMER_BIT     6
`define LP_WMASK          8'h77
`define LP_FIXED          8'h08

`endif

//--- hw/line_test_loopback_counters.v
`include "line_test_map.vh"

module line_test_loopback_counters (
  input  wire       clk_sys_i,
  input  wire       rstn_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  output wire [7:0] reg_rdata_o,
  input  wire       frame_valid_i,
  input  wire [7:0] sys_b1_i,
  input  wire [7:0] sys_b2_i,
  input  wire [1:0] sys_d_i,
  input  wire [7:0] line_b1_i,
  input  wire [7:0] line_b2_i,
  input  wire [1:0] line_d_i,
  input  wire       far_end_err_i,
  input  wire       near_end_err_i,
  input  wire       single_pulse_test_i,
  output wire       sys_valid_o,
  output wire [7:0] sys_b1_o,
  output wire [7:0] sys_b2_o,
  output wire [1:0] sys_d_o,
  output wire       line_valid_o,
  output wire [7:0] line_b1_o,
  output wire [7:0] line_b2_o,
  output wire [1:0] line_d_o,
  output wire       crc_invert_o,
  output wire       level_reduce_o,
  output wire       test_tone_o,
  output wire       framer_loop_o
);

  // --------------------------------------------------------------------------
  // Control register state
  // --------------------------------------------------------------------------
  reg  [7:0]  test_mode_reg;
  reg  [7:0]  test_mode_next;
  reg  [7:0]  loop_reg;
  reg  [7:0]  loop_next;

  // --------------------------------------------------------------------------
  // Counter state
  // --------------------------------------------------------------------------
  reg  [7:0]  far_end_reg;
  reg  [7:0]  far_end_next;
  reg  [7:0]  near_end_reg;
  reg  [7:0]  near_end_next;
  reg  [15:0] bit_err_reg;
  reg  [15:0] bit_err_next;

  // --------------------------------------------------------------------------
  // Register port, pulse level and frame path state
  // --------------------------------------------------------------------------
  reg  [7:0]  rdata_reg;
  reg  [7:0]  rdata_next;
  reg         level_reduce_reg;
  reg         sys_valid_reg;
  reg  [17:0] sys_data_reg;
  reg  [17:0] sys_data_next;
  reg         line_valid_reg;
  reg  [17:0] line_data_reg;
  reg  [17:0] line_data_next;

  // --------------------------------------------------------------------------
  // Field decode
  // --------------------------------------------------------------------------
  wire [1:0]  error_measure_select = test_mode_reg[`TM_SEL_HI:`TM_SEL_LO];
  wire        measure_on           = (error_measure_select != `SEL_OFF);
  wire        framer_loop_close    = loop_reg[`LP_FRAMER_BIT];
  wire        loop_transparency_select = loop_reg[`LP_LOOP_TRANSPARENCY_SELECT_BIT];
  wire        loop_direction_select    = loop_reg[`LP_DIR_BIT];
  wire        full_channel_loop    = loop_reg[`LP_FULL_BIT];
  wire        second_channel_loop  = loop_reg[`LP_B2_BIT];
  wire        first_channel_loop   = loop_reg[`LP_B1_BIT];

  // --------------------------------------------------------------------------
  // Channel packing and loop selection
  // --------------------------------------------------------------------------
  // Channels packed as {D, B2, B1}
  wire [17:0] sys_in  = {sys_d_i, sys_b2_i, sys_b1_i};
  wire [17:0] line_in = {line_d_i, line_b2_i, line_b1_i};

  wire        loop_b1 = full_channel_loop | first_channel_loop;
  wire        loop_b2 = full_channel_loop | second_channel_loop;
  wire        loop_d  = full_channel_loop;
  wire [17:0] loop_mask = {{2{loop_d}}, {8{loop_b2}}, {8{loop_b1}}};

  // --------------------------------------------------------------------------
  // Register strobe decode
  // --------------------------------------------------------------------------
  wire        rd_far_end  = reg_rd_i & (reg_addr_i == `ADDR_FAR_END);
  wire        rd_near_end = reg_rd_i & (reg_addr_i == `ADDR_NEAR_END);
  wire        rd_bit_hi   = reg_rd_i & (reg_addr_i == `ADDR_BIT_ERR_HI);
  wire        ber_event   = measure_on & frame_valid_i;

  reg  [17:0] zero_mask;

  // --------------------------------------------------------------------------
  // Measurement channel selection
  // --------------------------------------------------------------------------
  always @* begin
    case (error_measure_select)
      `SEL_B1:  zero_mask = {2'b00, 8'h00, 8'hff};
      `SEL_B2:  zero_mask = {2'b00, 8'hff, 8'h00};
      `SEL_ALL: zero_mask = {2'b11, 8'hff, 8'hff};
      default:  zero_mask = {2'b00, 8'h00, 8'h00};
    endcase
  end

  // --------------------------------------------------------------------------
  // Loop merge terms
  // --------------------------------------------------------------------------
  // Looped slots come back, the rest passes through
  wire [17:0] host_merge = (loop_mask & sys_in) | (~loop_mask & line_in);
  wire [17:0] line_merge = (loop_mask & line_in) | (~loop_mask & sys_in);
  // Idle code of all ones fills the looped slots of the forwarded stream
  wire [17:0] line_idle  = loop_mask | sys_in;
  wire [17:0] host_idle  = loop_mask | line_in;

  // --------------------------------------------------------------------------
  // Loop routing
  // --------------------------------------------------------------------------
  always @* begin
    if (framer_loop_close) begin
      // User data back to the host and still sent on, never idle-substituted
      sys_data_next  = sys_in;
      line_data_next = sys_in;
    end else if (!loop_direction_select) begin
      // Loops closed towards the host serial side
      sys_data_next = host_merge;
      if (loop_transparency_select) begin
        line_data_next = line_idle;
      end else begin
        line_data_next = sys_in;
      end
    end else begin
      // Loops closed towards the line
      line_data_next = line_merge;
      if (loop_transparency_select) begin
        sys_data_next = host_idle;
      end else begin
        sys_data_next = line_in;
      end
    end
    // Zeros replace user data in the measured channels
    line_data_next = line_data_next & ~zero_mask;
    // Outputs keep the last frame between frame slots
    if (!frame_valid_i) begin
      sys_data_next  = sys_data_reg;
      line_data_next = line_data_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Bit error detection on the returned zeros
  // --------------------------------------------------------------------------
  // Running sum of received ones inside the measured channels
  wire [4:0]  err_chain [0:18];
  wire [4:0]  err_bits;
  wire [16:0] ber_sum;

  assign err_chain[0] = 5'h00;

  genvar g;
  generate
    for (g = 0; g < 18; g = g + 1) begin : g_err_bit
      wire hit = line_in[g] & zero_mask[g];
      assign err_chain[g+1] = err_chain[g] + {4'h0, hit};
    end
  endgenerate

  assign err_bits = err_chain[18];
  assign ber_sum  = {1'b0, bit_err_reg} + {12'h000, err_bits};

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always @* begin
    test_mode_next = test_mode_reg;
    loop_next      = loop_reg;
    if (reg_wr_i && reg_addr_i == `ADDR_TEST_MODE) begin
      test_mode_next = (reg_wdata_i & `TM_WMASK) | `TM_FIXED;
    end else if (reg_wr_i && reg_addr_i == `ADDR_LOOPBACK) begin
      loop_next = (reg_wdata_i & `LP_WMASK) | `LP_FIXED;
    end
  end

  // --------------------------------------------------------------------------
  // Far-end block error counter
  // --------------------------------------------------------------------------
  // Read clears; an error arriving in the same cycle is kept
  always @* begin
    if (rd_far_end) begin
      far_end_next = {7'h00, far_end_err_i};
    end else if (far_end_err_i && far_end_reg != 8'hff) begin
      far_end_next = far_end_reg + 8'h01;
    end else begin
      far_end_next = far_end_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Near-end block error counter
  // --------------------------------------------------------------------------
  always @* begin
    if (rd_near_end) begin
      near_end_next = {7'h00, near_end_err_i};
    end else if (near_end_err_i && near_end_reg != 8'hff) begin
      near_end_next = near_end_reg + 8'h01;
    end else begin
      near_end_next = near_end_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Bit error counter
  // --------------------------------------------------------------------------
  always @* begin
    if (rd_bit_hi) begin
      // Only the upper byte read clears the count
      if (ber_event) begin
        bit_err_next = {11'h000, err_bits};
      end else begin
        bit_err_next = `RST_COUNT16;
      end
    end else if (measure_on && frame_valid_i) begin
      if (ber_sum[16]) begin
        bit_err_next = 16'hffff;
      end else begin
        bit_err_next = ber_sum[15:0];
      end
    end else begin
      bit_err_next = bit_err_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always @* begin
    if (!reg_rd_i) begin
      rdata_next = 8'h00;
    end else if (reg_addr_i == `ADDR_TEST_MODE) begin
      rdata_next = test_mode_reg;
    end else if (reg_addr_i == `ADDR_LOOPBACK) begin
      rdata_next = loop_reg;
    end else if (reg_addr_i == `ADDR_FAR_END) begin
      rdata_next = far_end_reg;
    end else if (reg_addr_i == `ADDR_NEAR_END) begin
      rdata_next = near_end_reg;
    end else if (reg_addr_i == `ADDR_BIT_ERR_LO) begin
      rdata_next = bit_err_reg[7:0];
    end else if (reg_addr_i == `ADDR_BIT_ERR_HI) begin
      rdata_next = bit_err_reg[15:8];
    end else begin
      rdata_next = 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Pulse level next value
  // --------------------------------------------------------------------------
  // Reduced pulses only matter while a tone or single pulse is sent
  wire        level_reduce_next = test_mode_reg[`TM_REDUCE_BIT] &
                                  (test_mode_reg[`TM_TONE_BIT] | single_pulse_test_i);

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      test_mode_reg <= `RST_TEST_MODE;
      loop_reg      <= `RST_LOOPBACK;
    end else begin
      test_mode_reg <= test_mode_next;
      loop_reg      <= loop_next;
    end
  end

  // --------------------------------------------------------------------------
  // Error counters
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      far_end_reg  <= `RST_COUNT8;
      near_end_reg <= `RST_COUNT8;
      bit_err_reg  <= `RST_COUNT16;
    end else begin
      far_end_reg  <= far_end_next;
      near_end_reg <= near_end_next;
      bit_err_reg  <= bit_err_next;
    end
  end

  // --------------------------------------------------------------------------
  // Read data and pulse level
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rdata_reg        <= 8'h00;
      level_reduce_reg <= 1'b0;
    end else begin
      rdata_reg        <= rdata_next;
      level_reduce_reg <= level_reduce_next;
    end
  end

  // --------------------------------------------------------------------------
  // Frame path
  // --------------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sys_valid_reg  <= 1'b0;
      line_valid_reg <= 1'b0;
      sys_data_reg   <= 18'h00000;
      line_data_reg  <= 18'h00000;
    end else begin
      sys_valid_reg  <= frame_valid_i;
      line_valid_reg <= frame_valid_i;
      sys_data_reg   <= sys_data_next;
      line_data_reg  <= line_data_next;
    end
  end

  // --------------------------------------------------------------------------
  // Register port output
  // --------------------------------------------------------------------------
  assign reg_rdata_o    = rdata_reg;

  // --------------------------------------------------------------------------
  // Frame outputs
  // --------------------------------------------------------------------------
  assign sys_valid_o    = sys_valid_reg;
  assign sys_b1_o       = sys_data_reg[7:0];
  assign sys_b2_o       = sys_data_reg[15:8];
  assign sys_d_o        = sys_data_reg[17:16];
  assign line_valid_o   = line_valid_reg;
  assign line_b1_o      = line_data_reg[7:0];
  assign line_b2_o      = line_data_reg[15:8];
  assign line_d_o       = line_data_reg[17:16];

  // --------------------------------------------------------------------------
  // Line coder controls
  // --------------------------------------------------------------------------
  assign crc_invert_o   = test_mode_reg[`TM_CRC_BIT];
  assign level_reduce_o = level_reduce_reg;
  assign test_tone_o    = test_mode_reg[`TM_TONE_BIT];
  assign framer_loop_o  = framer_loop_close;

endmodule

//--- test/line_test_loopback_counters_assertions.sv
module line_test_checker (
  input wire       clk_sys_i,
  input wire       rstn_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_wr_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire       frame_valid_i,
  input wire [7:0] sys_b1_i,
  input wire       far_end_err_i,
  input wire       single_pulse_test_i,
  input wire [7:0] sys_b1_o,
  input wire       crc_invert_o,
  input wire       level_reduce_o,
  input wire       test_tone_o,
  input wire       framer_loop_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data left standing");
  test_bits_a: assert property (reg_wr_i && reg_addr_i == 8'h0f |=>
    test_tone_o == $past(reg_wdata_i[0]) && crc_invert_o == $past(reg_wdata_i[3]))
    else $error("test controls not taken");
  framer_bit_a: assert property (reg_wr_i && reg_addr_i == 8'h10 |=>
    framer_loop_o == $past(reg_wdata_i[6])) else $error("framer loop bit not taken");
  reduce_cause_a: assert property (level_reduce_o |->
    $past(test_tone_o) || $past(single_pulse_test_i)) else $error("reduced pulses");
  far_clear_a: assert property (reg_rd_i && reg_addr_i == 8'h11 && !far_end_err_i ##1
    reg_rd_i && reg_addr_i == 8'h11 |=> reg_rdata_o == 8'h00) else $error("far not cleared");
  ber_clear_a: assert property (reg_rd_i && reg_addr_i == 8'h14 && !frame_valid_i ##1
    reg_rd_i && reg_addr_i == 8'h13 |=> reg_rdata_o == 8'h00) else $error("bit count kept");
  frame_hold_a: assert property (!frame_valid_i |=> $stable(sys_b1_o))
    else $error("host data moved without frame");
  framer_sys_a: assert property (framer_loop_o && frame_valid_i |=>
    sys_b1_o == $past(sys_b1_i)) else $error("framer loop data wrong");
  cover property (reg_rd_i && reg_addr_i == 8'h11 ##1 reg_rd_i && reg_addr_i == 8'h11);
  cover property (framer_loop_o && frame_valid_i);
  cover property (level_reduce_o && single_pulse_test_i);
endmodule
bind line_test_loopback_counters line_test_checker i_line_test_checker (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .frame_valid_i(frame_valid_i), .sys_b1_i(sys_b1_i),
  .far_end_err_i(far_end_err_i), .single_pulse_test_i(single_pulse_test_i),
  .sys_b1_o(sys_b1_o), .crc_invert_o(crc_invert_o), .level_reduce_o(level_reduce_o),
  .test_tone_o(test_tone_o), .framer_loop_o(framer_loop_o));

//--- test/remote_loop_model.sv
module remote_loop_model (
  input  wire         clk_i,
  input  wire         rstn_i,
  input  wire         valid_i,
  input  wire  [17:0] sent_i,
  input  wire  [17:0] flip_i,
  output logic [17:0] back_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] held_reg;
  // Far end loop, returns last frame with chosen bits flipped
  always @(posedge clk_i) begin
    if (!rstn_i)
      held_reg <= 18'h0;
    else if (valid_i)
      held_reg <= sent_i;
  end
  assign back_o = held_reg ^ flip_i;
endmodule

//--- test/line_test_loopback_counters_tb.sv
module line_test_loopback_counters_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, wr, rd, fv, fe, ne, spt;
  logic [7:0]  addr, wdata, sb1, sb2, lp, tm;
  logic [1:0]  sd;
  logic [17:0] flip;
  wire         sv, lv, crc, lvl, tone, fl;
  wire  [7:0]  rdata;
  wire  [17:0] lb, so, lo;
  int          err_total, n_checks, tally;
  logic [7:0]  lps [7] = '{8'h00, 8'h07, 8'h27, 8'h15, 8'h32, 8'h34, 8'h60};
  line_test_loopback_counters i_line_test_loopback_counters (
    .clk_sys_i(clk), .rstn_i(rstn), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .frame_valid_i(fv), .sys_b1_i(sb1), .sys_b2_i(sb2),
    .sys_d_i(sd), .line_b1_i(lb[17:10]), .line_b2_i(lb[9:2]), .line_d_i(lb[1:0]),
    .far_end_err_i(fe), .near_end_err_i(ne), .single_pulse_test_i(spt), .sys_valid_o(sv),
    .sys_b1_o(so[17:10]), .sys_b2_o(so[9:2]), .sys_d_o(so[1:0]), .line_valid_o(lv),
    .line_b1_o(lo[17:10]), .line_b2_o(lo[9:2]), .line_d_o(lo[1:0]), .crc_invert_o(crc),
    .level_reduce_o(lvl), .test_tone_o(tone), .framer_loop_o(fl));
  remote_loop_model i_remote_loop_model (
    .clk_i(clk), .rstn_i(rstn), .valid_i(lv), .sent_i(lo), .flip_i(flip), .back_o(lb));
  task automatic chk(input logic [17:0] e, g, input string nm);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    if (a == 8'h0f) tm = d;
    if (a == 8'h10) lp = d;
  endtask
  // Optional second address gives two reads back to back
  task automatic rchk(input logic [7:0] a, e, b = 8'h00);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    if (b != 8'h00) begin
      @(posedge clk);
      addr <= b;
    end
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({10'h0, e}, {10'h0, rdata}, "read data");
  endtask
  task automatic frame(input logic [17:0] s);
    logic [17:0] m, z, l, es, el;
    @(posedge clk);
    fv <= 1'b1;
    {sb1, sb2, sd} <= s;
    #1;
    l = lb;
    m = {lp[2] | lp[0] ? 8'hff : 8'h00, lp[2] | lp[1] ? 8'hff : 8'h00, {2{lp[2]}}};
    z = {tm[4] ? 8'hff : 8'h00, tm[5] ? 8'hff : 8'h00, {2{&tm[5:4]}}};
    if (lp[6]) {es, el} = {s, s};
    else if (!lp[4]) {es, el} = {s & m | l & ~m, lp[5] ? s | m : s};
    else {es, el} = {lp[5] ? l | m : l, l & m | s & ~m};
    tally = tally + $countones(l & z);
    if (tally > 65535) tally = 65535;
    @(posedge clk);
    fv <= 1'b0;
    #1;
    chk(es, so, "sys data");
    chk(el & ~z, lo, "line data");
    chk(18'h3, {16'h0, sv, lv}, "valids");
  endtask
  task automatic test_done();
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rstn, wr, rd, fv, fe, ne, spt, addr, wdata, sb1, sb2, sd, flip} = '0;
    {err_total, n_checks, tally} = '0;
    lp = 8'h08;
    tm = 8'h40;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rchk(8'h0f, 8'h40);
    rchk(8'h10, 8'h08);
    rchk(8'h20, 8'h00);
    wreg(8'h0f, 8'hff);
    wreg(8'h10, 8'hff);
    rchk(8'h0f, 8'h7d);
    rchk(8'h10, 8'h7f);
    chk(18'hf, {14'h0, crc, tone, fl, lvl}, "controls");
    wreg(8'h0f, 8'h44);
    spt <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(18'h1, {17'h0, lvl}, "reduced pulses");
    wreg(8'h0f, 8'h40);
    fe <= 1'b1;
    repeat (3) @(posedge clk);
    fe <= 1'b0;
    ne <= 1'b1;
    repeat (300) @(posedge clk);
    ne <= 1'b0;
    rchk(8'h11, 8'h03);
    rchk(8'h11, 8'h00, 8'h11);
    rchk(8'h12, 8'hff);
    rchk(8'h12, 8'h00);
    flip <= 18'h2a5a5;
    foreach (lps[i]) begin
      wreg(8'h10, lps[i]);
      for (int s = 0; s < 4; s++) begin
        wreg(8'h0f, {2'b01, s[1:0], 4'h0});
        repeat (3) frame({lps[i] ^ 8'hc3, s[7:0] ^ 8'h96, i[1:0]});
      end
    end
    wreg(8'h0f, 8'h40);
    frame(18'h3ffff);
    rchk(8'h13, tally[7:0]);
    rchk(8'h13, tally[7:0]);
    rchk(8'h14, tally[15:8]);
    rchk(8'h14, 8'h00, 8'h13);
    test_done();
  end
endmodule
